// ---- logic/bsws_cfg.svh ----
`ifndef BSWS_CFG_SVH
`define BSWS_CFG_SVH
`define BSWS_LANES       4
`define BSWS_DATA_W      32
`define BSWS_BURST_W     2
`define BSWS_INT_STEP1   2'h1
`define BSWS_INT_STEP2   2'h2
`define BSWS_INT_STEP3   2'h3
`define BSWS_LIN_INC     2'h1
`define BSWS_RST_BEAT    2'h0
`endif

// ---- logic/bsws_pkg.sv ----
package bsws_pkg;
   typedef logic [1:0] bsws_addr_t;
   typedef enum logic [1:0] {
      BSWS_IDLE  = 2'h0,
      BSWS_READ  = 2'h1,
      BSWS_WRITE = 2'h3,
      BSWS_SLEEP = 2'h2
   } bsws_mode_e;
endpackage

// ---- logic/bsws_burst_if.sv ----
`timescale 1ns/1ps
interface bsws_burst_if;
   logic                 load;
   logic                 step;
   logic                 order_interleaved;
   bsws_pkg::bsws_addr_t start_addr;
   bsws_pkg::bsws_addr_t cur_addr;
   modport ctrl (output load, output step, output order_interleaved, output start_addr,
                 input cur_addr);
   modport ctr  (input load, input step, input order_interleaved, input start_addr,
                 output cur_addr);
endinterface

// ---- logic/bsws_burst_ctr.sv ----
`timescale 1ns/1ps
`include "bsws_cfg.svh"
module bsws_burst_ctr (
   input  wire logic     clk_sys,
   input  wire logic     rst,
   bsws_burst_if.ctr     bus
);
   typedef struct packed {
      bsws_pkg::bsws_addr_t start;
      bsws_pkg::bsws_addr_t beat;
   } bsws_ctr_s;

   bsws_ctr_s st_ff;
   bsws_ctr_s nxt_st;

   // beat counts 0..3 and wraps, so the fifth access is the start again
   always_comb begin
      nxt_st = st_ff;
      if (bus.load) begin
         nxt_st.start = bus.start_addr;
         nxt_st.beat  = `BSWS_RST_BEAT;
      end else if (bus.step) begin
         nxt_st.beat = st_ff.beat + `BSWS_LIN_INC;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      if (bus.order_interleaved) begin
         bus.cur_addr = st_ff.start ^ st_ff.beat;
      end else begin
         bus.cur_addr = st_ff.start + st_ff.beat;
      end
   end
endmodule // bsws_burst_ctr

// ---- logic/bsws_core.sv ----
`timescale 1ns/1ps
`include "bsws_cfg.svh"
// Behaviour
// - global write low writes all four lanes; otherwise read when lane enable high.
// - lane enable low writes exactly the lanes whose select is low.
// - selected read drives data only while output enable is low.
// - write cycle keeps outputs off and accepts all 32 input lines.
// - deselected keeps data lines off and signals standby.
// - sleep high forces data lines off regardless of other controls.
// - interleaved order xors start bits with 01, 10, 11.
// - linear order adds one modulo four from the start bits.
// - after the fourth access the counter wraps to the start.
// - advance low without new strobe steps to the next burst address.
// - advance high without new strobe holds the current burst address.
module bsws_core #(
   parameter int DATA_W = `BSWS_DATA_W,
   parameter int LANES  = `BSWS_LANES
) (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         select,
   input  wire logic                         new_burst,
   input  wire logic [1:0]                   addr_low,
   input  wire logic                         burst_advance_n,
   input  wire logic                         global_write_n,
   input  wire logic                         lane_write_enable_n,
   input  wire logic [LANES-1:0]             byte_lane_select_n,
   input  wire logic                         burst_order_select,
   input  wire logic                         output_enable_n,
   input  wire logic                         sleep_request,
   input  wire logic [DATA_W-1:0]            data_in,
   input  wire logic [DATA_W-1:0]            read_data,
   output logic      [DATA_W-1:0]            data_out,
   output logic                              data_oe,
   output logic      [LANES-1:0]             lane_write,
   output logic      [DATA_W-1:0]            write_data,
   output logic      [1:0]                   burst_addr,
   output logic                              standby,
   output logic                              sleeping
);
   typedef struct packed {
      bsws_pkg::bsws_mode_e  mode;
      logic [LANES-1:0]      lanes;
      logic [DATA_W-1:0]     wdata;
      logic [DATA_W-1:0]     rdata;
      logic                  sleep_s1;
      logic                  sleep_s2;
      logic                  sleep_s3;
      logic                  sleep_lvl;
   } bsws_core_s;

   bsws_core_s st_ff;
   bsws_core_s nxt_st;

   bsws_burst_if burst ();

   function automatic logic [LANES-1:0] lane_decode(
      input logic gw_n, input logic bwe_n, input logic [LANES-1:0] sel_n);
      if (!gw_n) begin
         lane_decode = '1;
      end else if (!bwe_n) begin
         lane_decode = ~sel_n;
      end else begin
         lane_decode = '0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // burst counter; order pin is treated as static and not synchronised
   assign burst.load              = select && new_burst;
   assign burst.step              = !new_burst && !burst_advance_n;
   assign burst.order_interleaved = burst_order_select;
   assign burst.start_addr        = addr_low;

   bsws_burst_ctr u_ctr (
      .clk_sys (clk_sys),
      .rst     (rst),
      .bus     (burst.ctr)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.lanes = '0;
      // sleep pin is asynchronous: three stages, change counted when last two agree
      nxt_st.sleep_s1 = sleep_request;
      nxt_st.sleep_s2 = st_ff.sleep_s1;
      nxt_st.sleep_s3 = st_ff.sleep_s2;
      if (st_ff.sleep_s2 == st_ff.sleep_s3) begin
         nxt_st.sleep_lvl = st_ff.sleep_s3;
      end
      if (st_ff.sleep_lvl) begin
         nxt_st.mode = bsws_pkg::BSWS_SLEEP;
      end else if (new_burst && !select) begin
         nxt_st.mode = bsws_pkg::BSWS_IDLE;
      end else if (st_ff.mode != bsws_pkg::BSWS_IDLE || new_burst) begin
         // a burst continues past sleep only once a fresh select arrives
         if (st_ff.mode == bsws_pkg::BSWS_SLEEP && !new_burst) begin
            nxt_st.mode = bsws_pkg::BSWS_IDLE;
         end else begin
            nxt_st.lanes = lane_decode(global_write_n, lane_write_enable_n,
                                       byte_lane_select_n);
            nxt_st.mode  = (nxt_st.lanes != '0) ? bsws_pkg::BSWS_WRITE
                                                : bsws_pkg::BSWS_READ;
            nxt_st.wdata = data_in;
         end
      end
      nxt_st.rdata = read_data;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output enable acts without the clock, so the driver gate stays combinational
   assign data_oe    = (st_ff.mode == bsws_pkg::BSWS_READ) && !output_enable_n
                       && !st_ff.sleep_lvl;
   assign data_out   = st_ff.rdata;
   assign lane_write = st_ff.lanes;
   assign write_data = st_ff.wdata;
   assign burst_addr = burst.cur_addr;
   assign standby    = (st_ff.mode == bsws_pkg::BSWS_IDLE);
   assign sleeping   = (st_ff.mode == bsws_pkg::BSWS_SLEEP);
endmodule // bsws_core

// ---- verification/bsws_chk.sv ----
`timescale 1ns/1ps
module bsws_chk (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       select,
   input wire logic       new_burst,
   input wire logic [1:0] addr_low,
   input wire logic       burst_advance_n,
   input wire logic       global_write_n,
   input wire logic       burst_order_select,
   input wire logic       output_enable_n,
   input wire logic       data_oe,
   input wire logic [3:0] lane_write,
   input wire logic [1:0] burst_addr,
   input wire logic       standby,
   input wire logic       sleeping
);
   wire go = new_burst & select & !sleeping;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_all_lanes: assert property (go & !global_write_n |=> lane_write == 4'hf)
      else $error("lanes");
   a_oe_off: assert property (output_enable_n |-> !data_oe) else $error("oe");
   a_read_drive: assert property (!standby & !sleeping & lane_write == 4'h0
      & !output_enable_n |-> data_oe) else $error("drive");
   a_write_off: assert property (|lane_write |-> !data_oe) else $error("wr");
   a_desel_off: assert property (standby |-> !data_oe) else $error("desel");
   a_sleep_off: assert property (sleeping |-> !data_oe) else $error("zz");
   a_load_start: assert property (go |=> burst_addr == $past(addr_low))
      else $error("load");
   a_linear_step: assert property (!new_burst & !burst_advance_n & !standby
      & !burst_order_select & !sleeping |=> burst_addr == $past(burst_addr) + 2'h1)
      else $error("step");
   c_write: cover property (go & !global_write_n);
   c_read: cover property (data_oe);
   c_sleep: cover property (sleeping);
endmodule // bsws_chk
bind bsws_core bsws_chk i_bsws_chk (.*);

// ---- verification/bsws_ctl_model.sv ----
`timescale 1ns/1ps
module bsws_ctl_model (
   input  wire logic        clk_sys,
   output logic      [13:0] ctl
);
   // levels persist between calls so async controls see a defined operation
   initial ctl = 14'h0800;
   task automatic op(input logic [12:0] v);
      @(negedge clk_sys);
      ctl[12:0] <= v;
   endtask
   // order only moves while deselected
   task automatic cfg(input logic o);
      @(negedge clk_sys);
      ctl[13] <= o;
   endtask
endmodule // bsws_ctl_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
   logic        clk_sys = 1'b0, rst = 1'b1;
   logic [31:0] data_in = 32'h0, read_data = 32'h0, seed = 32'h7b9147b5, r;
   wire  [13:0] ctl;
   wire         select, new_burst, burst_advance_n, global_write_n, lane_write_enable_n;
   wire         burst_order_select, output_enable_n, sleep_request;
   wire  [1:0]  addr_low;
   wire  [3:0]  byte_lane_select_n;
   logic [31:0] data_out, write_data;
   logic [3:0]  lane_write;
   logic [1:0]  burst_addr;
   logic        data_oe, standby, sleeping;
   int          n_errors = 0, num_checks = 0, md = 0, st = 0, bt = 0, slp = 0;
   int          zq[$] = '{0, 0, 0, 0};
   assign {burst_order_select, select, new_burst, addr_low, burst_advance_n, global_write_n,
           lane_write_enable_n, byte_lane_select_n, output_enable_n, sleep_request} = ctl;
   always #2.5 clk_sys = ~clk_sys;
   bsws_ctl_model i_bsws_ctl_model (.clk_sys, .ctl);
   bsws_core i_bsws_core (.*);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("%0d checks %0d errors", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic step(input logic [12:0] v);
      logic [3:0] e;
      i_bsws_ctl_model.op(v);
      data_in = rnd();
      read_data = rnd();
      zq.push_back(v[0]); // sleep shows on the fifth edge after the pin moves
      slp = zq.pop_front();
      if (v[11]) begin
         md = v[12];
         st = v[10:9];
         bt = 0;
      end else if (md != 0 && !v[8]) bt = (bt + 1) % 4;
      e = md == 0 ? 4'h0 : !v[7] ? 4'hf : !v[6] ? ~v[5:2] : 4'h0;
      @(posedge clk_sys);
      #1;
      chk(lane_write, e);
      chk(standby, md == 0 && slp == 0);
      chk(sleeping, slp);
      chk(data_out, read_data);
      chk(data_oe, md != 0 && e == 0 && !v[1]);
      if (md != 0) chk(burst_addr, burst_order_select ? st ^ bt : (st + bt) % 4);
      if (e != 0) chk(write_data, data_in);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      chk(standby, 1'b1);
      repeat (6) step(13'h0801); // sleep entered while deselected; left by the next six steps
      chk(sleeping, 1'b1);
      repeat (6) step(13'h0800);
      chk(sleeping, 1'b0);
      for (int o = 0; o < 2; o++) begin
         step(13'h0800);
         i_bsws_ctl_model.cfg(o[0]);
         repeat (150) begin
            r = rnd();
            step({|r[1:0], ~|r[4:2], r[6:5], r[7], |r[9:8], r[10], r[14:11], r[15], 1'b0});
         end
      end
      print_verdict();
   end
   initial begin
      #10000;
      n_errors++;
      print_verdict();
   end
endmodule // tb
